/* hdl/ase_pkg.sv */
// Constants, register map and types of the asynchronous serial port.
package ase_pkg;
  // ****************************************
  // Register map, byte offsets
  // ****************************************
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFF_CTRL = 3'h0;
  localparam logic [2:0] OFF_BAUD_LO = 3'h1;
  localparam logic [2:0] OFF_STAT1 = 3'h2;
  localparam logic [2:0] OFF_MASK = 3'h3;
  localparam logic [2:0] OFF_DATA_HI = 3'h4;
  localparam logic [2:0] OFF_DATA_LO = 3'h5;
  localparam logic [2:0] OFF_BAUD_HI = 3'h6;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_FRAME_LONG = 0;
  localparam int CTRL_TX_EN = 1;
  localparam int CTRL_RX_EN = 2;
  localparam int CTRL_BREAK = 3;
  localparam int FLG_OVERRUN = 3;
  localparam int FLG_IDLE = 4;
  localparam int FLG_RX_FULL = 5;
  localparam int FLG_TX_DONE = 6;
  localparam int FLG_TX_EMPTY = 7;
  localparam int DHI_RX_BIT8 = 7;
  localparam int DHI_TX_BIT8 = 6;
  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  localparam int BAUD_W = 16;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] SUB_LAST = 4'hf;
  localparam logic [3:0] SUB_MID = 4'h7;
  localparam logic [3:0] BITS_SHORT = 4'ha;
  localparam logic [3:0] BITS_LONG = 4'hb;

  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} ase_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_START = 3'b010, RX_DATA = 3'b100} ase_rx_state_t;

  // Bits in one frame, start and stop included.
  function automatic logic [3:0] ase_frame_bits(input logic frame_long);
    ase_frame_bits = frame_long ? BITS_LONG : BITS_SHORT;
  endfunction
endpackage

/* hdl/ase_rx_if.sv */
// Link between the register core and the receive engine.
`timescale 1ns/1ps
interface ase_rx_if;
  logic tick;
  logic frame_long;
  logic rx_en;
  logic done;
  logic [8:0] data;
  logic idle_hit;
  modport rcv (input tick, input frame_long, input rx_en, output done, output data, output idle_hit);
  modport ctl (output tick, output frame_long, output rx_en, input done, input data, input idle_hit);
endinterface

/* hdl/ase_rcv.sv */
// Receive engine: oversampled frame capture and idle line detection.
`timescale 1ns/1ps
module ase_rcv (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic rxd,
  ase_rx_if.rcv lnk
);
  import ase_pkg::*;

  ase_rx_state_t state_reg;
  logic [3:0] sub_reg;
  logic [3:0] bit_reg;
  logic [8:0] shift_reg;
  logic [7:0] idle_cnt_reg;
  logic done_reg;
  logic hit_reg;
  logic [3:0] data_bits;
  logic [7:0] idle_limit;

  assign data_bits = ase_frame_bits(lnk.frame_long) - 4'h2;
  assign idle_limit = {ase_frame_bits(lnk.frame_long), 4'h0} - 8'h01;
  assign lnk.done = done_reg;
  assign lnk.idle_hit = hit_reg;
  assign lnk.data = lnk.frame_long ? shift_reg : {1'b0, shift_reg[8:1]};

  // ****************************************
  // Frame capture
  // ****************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= RX_IDLE;
      sub_reg <= 4'h0;
      bit_reg <= 4'h0;
      shift_reg <= 9'h000;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (!lnk.rx_en) begin
        state_reg <= RX_IDLE;
      end else if (lnk.tick) begin
        sub_reg <= sub_reg + 4'h1;
        case (state_reg)
          RX_IDLE: begin
            sub_reg <= 4'h0;
            if (!rxd) begin
              state_reg <= RX_START;
            end
          end
          RX_START: begin
            if (sub_reg == SUB_MID) begin
              sub_reg <= 4'h0;
              bit_reg <= 4'h0;
              state_reg <= rxd ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (sub_reg == SUB_LAST) begin
              if (bit_reg == data_bits) begin
                done_reg <= 1'b1;
                state_reg <= RX_IDLE;
              end else begin
                shift_reg <= {rxd, shift_reg[8:1]};
                bit_reg <= bit_reg + 4'h1;
              end
            end
          end
          default: state_reg <= RX_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Idle line: a frame's worth of ones
  // ****************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      idle_cnt_reg <= 8'h00;
      hit_reg <= 1'b0;
    end else begin
      hit_reg <= 1'b0;
      if (!lnk.rx_en || !rxd || state_reg != RX_IDLE) begin
        idle_cnt_reg <= 8'h00;
      end else if (lnk.tick && idle_cnt_reg <= idle_limit) begin
        idle_cnt_reg <= idle_cnt_reg + 8'h01;
        hit_reg <= (idle_cnt_reg == idle_limit);
      end
    end
  end
endmodule

/* hdl/ase_top.sv */
// Asynchronous serial port with its flag and interrupt logic.
// Function
// - One active-high interrupt output carries the OR of all interrupt sources enabled in the mask register.
// - Transmit-empty sets when the shifter takes a byte from the data register.
// - Transmit-empty clears after a status-one read with it set and then a data-low write.
// - Transmit-complete sets when transmit-empty is set and nothing is being shifted out or queued.
// - While transmit-complete is set the serial output idles high.
// - Transmit-complete clears after a status-one read with it set and then a data-low write.
// - Transmit-complete clears by itself once data, preamble or break is queued.
// - Receive-full sets when a received frame moves into the data register.
// - Receive-full clears after a status-one read with it set and then a data-low read.
// - Overrun sets when a frame completes before the held byte was read.
// - On overrun the new frame is dropped and the held byte stays.
// - Overrun clears after a status-one read with it set and then a data-low read.
// - Idle sets after 10 high bits on the input, or 11 with the long frame selected.
// - After idle is cleared it cannot set again until a frame has set receive-full.
// - Idle clears after a status-one read with it set and then a data-low read.
// - A pending interrupt request wakes the processor from wait mode.
`timescale 1ns/1ps
module ase_top #(
  parameter int DIV_W = ase_pkg::BAUD_W
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [ase_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic rxd_in,
  output logic txd_out,
  output logic irq_out,
  input wire logic wait_mode,
  output logic wake_out
);
  import ase_pkg::*;

  if (DIV_W < 1 || DIV_W > BAUD_W) begin : g_bad_div
    $error("DIV_W must lie between 1 and 16.");
  end

  ase_rx_if rx_lnk ();

  logic [7:0] ctrl_reg;
  logic [7:0] mask_reg;
  logic [15:0] baud_reg;
  logic [DIV_W-1:0] div_cnt_reg;
  logic tick_reg;
  logic [7:0] arm_reg;
  logic [7:0] rdata_reg;
  logic irq_reg;
  logic wake_reg;
  logic txd_reg;
  logic transmit_empty_flag_reg;
  logic tc_reg;
  logic receive_full_flag_reg;
  logic or_reg;
  logic idle_reg;
  logic idle_arm_reg;
  logic [8:0] rx_data_reg;
  logic [7:0] tx_data_reg;
  logic tx_bit8_reg;
  logic data_pend_reg;
  logic pre_pend_reg;
  logic tx_en_d_reg;
  ase_tx_state_t tx_state_reg;
  logic [3:0] tx_sub_reg;
  logic [3:0] tx_left_reg;
  logic [10:0] tx_shift_reg;
  logic frame_long;
  logic stat_rd;
  logic stat_wr;
  logic dl_rd;
  logic dl_wr;
  logic any_pend;
  logic tx_load;
  logic load_pre;
  logic load_brk;
  logic load_data;
  logic receive_full_flag_set;
  logic receive_full_flag_clr;
  logic or_set;
  logic or_clr;
  logic transmit_empty_flag_clr;
  logic tc_set;
  logic tc_clr;
  logic idle_set;
  logic idle_clr;
  logic [7:0] flags;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  assign frame_long = ctrl_reg[CTRL_FRAME_LONG];
  assign stat_rd = reg_rd && hit(reg_addr, OFF_STAT1);
  assign stat_wr = reg_wr && hit(reg_addr, OFF_STAT1);
  assign dl_rd = reg_rd && hit(reg_addr, OFF_DATA_LO);
  assign dl_wr = reg_wr && hit(reg_addr, OFF_DATA_LO);
  assign flags = {transmit_empty_flag_reg, tc_reg, receive_full_flag_reg, idle_reg, or_reg, 3'b000};

  assign rx_lnk.tick = tick_reg;
  assign rx_lnk.frame_long = frame_long;
  assign rx_lnk.rx_en = ctrl_reg[CTRL_RX_EN];

  ase_rcv u_rcv (
    .core_clk(core_clk),
    .resetn(resetn),
    .rxd(rxd_in),
    .lnk(rx_lnk)
  );

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= CTRL_RST;
      mask_reg <= MASK_RST;
      baud_reg <= BAUD_RST;
      tx_bit8_reg <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        OFF_CTRL: ctrl_reg <= reg_wdata;
        OFF_MASK: mask_reg <= reg_wdata & 8'hf8;
        OFF_BAUD_LO: baud_reg[7:0] <= reg_wdata;
        OFF_BAUD_HI: baud_reg[15:8] <= reg_wdata;
        OFF_DATA_HI: tx_bit8_reg <= reg_wdata[DHI_TX_BIT8];
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // Read data stand one cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        OFF_CTRL: rdata_reg <= ctrl_reg;
        OFF_MASK: rdata_reg <= mask_reg;
        OFF_BAUD_LO: rdata_reg <= baud_reg[7:0];
        OFF_BAUD_HI: rdata_reg <= baud_reg[15:8];
        OFF_STAT1: rdata_reg <= flags;
        OFF_DATA_HI: rdata_reg <= {rx_data_reg[8], tx_bit8_reg, 6'h00};
        OFF_DATA_LO: rdata_reg <= rx_data_reg[7:0];
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end
  assign reg_rdata = rdata_reg;

  // A status-one read remembers which flags were set; the next data-low access consumes that.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      arm_reg <= 8'h00;
    end else if (stat_rd) begin
      arm_reg <= flags;
    end else if (dl_rd || dl_wr) begin
      arm_reg <= 8'h00;
    end
  end

  // ****************************************
  // Baud rate: 16x oversampling enable
  // ****************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= 1'b0;
      if (baud_reg[DIV_W-1:0] == '0) begin
        div_cnt_reg <= '0;
      end else if (div_cnt_reg >= baud_reg[DIV_W-1:0] - 1'b1) begin
        div_cnt_reg <= '0;
        tick_reg <= 1'b1;
      end else begin
        div_cnt_reg <= div_cnt_reg + 1'b1;
      end
    end
  end

  // ****************************************
  // Transmit queue and shifter
  // ****************************************
  assign any_pend = data_pend_reg || pre_pend_reg || ctrl_reg[CTRL_BREAK];
  assign tx_load = tx_state_reg == TX_IDLE && ctrl_reg[CTRL_TX_EN] && any_pend;
  assign load_pre = tx_load && pre_pend_reg;
  assign load_brk = tx_load && !pre_pend_reg && ctrl_reg[CTRL_BREAK];
  assign load_data = tx_load && !pre_pend_reg && !ctrl_reg[CTRL_BREAK];

  // Enabling the transmitter queues one idle preamble.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_en_d_reg <= 1'b0;
      pre_pend_reg <= 1'b0;
    end else begin
      tx_en_d_reg <= ctrl_reg[CTRL_TX_EN];
      if (ctrl_reg[CTRL_TX_EN] && !tx_en_d_reg) begin
        pre_pend_reg <= 1'b1;
      end else if (load_pre) begin
        pre_pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_data_reg <= 8'h00;
      data_pend_reg <= 1'b0;
    end else if (dl_wr) begin
      tx_data_reg <= reg_wdata;
      data_pend_reg <= 1'b1;
    end else if (load_data) begin
      data_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_state_reg <= TX_IDLE;
      tx_sub_reg <= 4'h0;
      tx_left_reg <= 4'h0;
      tx_shift_reg <= 11'h7ff;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          tx_sub_reg <= 4'h0;
          if (tx_load) begin
            tx_state_reg <= TX_SHIFT;
            tx_left_reg <= ase_frame_bits(frame_long);
            if (load_pre) begin
              tx_shift_reg <= 11'h7ff;
            end else if (load_brk) begin
              tx_shift_reg <= 11'h000;
            end else begin
              tx_shift_reg <= {1'b1, frame_long ? tx_bit8_reg : 1'b1, tx_data_reg, 1'b0};
            end
          end
        end
        TX_SHIFT: begin
          if (tick_reg) begin
            tx_sub_reg <= tx_sub_reg + 4'h1;
            if (tx_sub_reg == SUB_LAST) begin
              tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
              tx_left_reg <= tx_left_reg - 4'h1;
              if (tx_left_reg == 4'h1) begin
                tx_state_reg <= TX_IDLE;
              end
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // The line rests high whenever nothing is being shifted.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      txd_reg <= 1'b1;
    end else if (tx_state_reg == TX_SHIFT) begin
      txd_reg <= tx_shift_reg[0];
    end else begin
      txd_reg <= 1'b1;
    end
  end
  assign txd_out = txd_reg;

  // ****************************************
  // Transmit flags
  // ****************************************
  assign transmit_empty_flag_clr = (dl_wr && arm_reg[FLG_TX_EMPTY]) || (stat_wr && reg_wdata[FLG_TX_EMPTY]);
  assign tc_set = transmit_empty_flag_reg && tx_state_reg == TX_IDLE && !any_pend;
  assign tc_clr = (dl_wr && arm_reg[FLG_TX_DONE]) || (stat_wr && reg_wdata[FLG_TX_DONE])
    || any_pend;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      transmit_empty_flag_reg <= 1'b1;
    end else if (load_data) begin
      transmit_empty_flag_reg <= 1'b1;
    end else if (transmit_empty_flag_clr) begin
      transmit_empty_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tc_reg <= 1'b1;
    end else if (tc_set) begin
      tc_reg <= 1'b1;
    end else if (tc_clr) begin
      tc_reg <= 1'b0;
    end
  end

  // ****************************************
  // Receive data and flags
  // ****************************************
  assign receive_full_flag_clr = (dl_rd && arm_reg[FLG_RX_FULL]) || (stat_wr && reg_wdata[FLG_RX_FULL]);
  assign receive_full_flag_set = rx_lnk.done && (!receive_full_flag_reg || receive_full_flag_clr);
  assign or_set = rx_lnk.done && receive_full_flag_reg && !receive_full_flag_clr;
  assign or_clr = (dl_rd && arm_reg[FLG_OVERRUN]) || (stat_wr && reg_wdata[FLG_OVERRUN]);
  assign idle_set = rx_lnk.idle_hit && idle_arm_reg;
  assign idle_clr = (dl_rd && arm_reg[FLG_IDLE]) || (stat_wr && reg_wdata[FLG_IDLE]);

  // A frame arriving while the held byte is unread is dropped.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_data_reg <= 9'h000;
    end else if (receive_full_flag_set) begin
      rx_data_reg <= rx_lnk.data;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      receive_full_flag_reg <= 1'b0;
    end else if (receive_full_flag_set) begin
      receive_full_flag_reg <= 1'b1;
    end else if (receive_full_flag_clr) begin
      receive_full_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      or_reg <= 1'b0;
    end else if (or_set) begin
      or_reg <= 1'b1;
    end else if (or_clr) begin
      or_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      idle_reg <= 1'b0;
    end else if (idle_set) begin
      idle_reg <= 1'b1;
    end else if (idle_clr) begin
      idle_reg <= 1'b0;
    end
  end

  // Clearing idle disarms detection until the next accepted frame.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      idle_arm_reg <= 1'b1;
    end else if (receive_full_flag_set) begin
      idle_arm_reg <= 1'b1;
    end else if (idle_reg && idle_clr && !idle_set) begin
      idle_arm_reg <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt and wake
  // ****************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      irq_reg <= |(flags & mask_reg);
      wake_reg <= wait_mode && |(flags & mask_reg);
    end
  end
  assign irq_out = irq_reg;
  assign wake_out = wake_reg;
endmodule

/* tb/ase_top_asserts.sv */
// Port-level assertions on the serial port flag and interrupt logic.
`timescale 1ns/1ps
module ase_top_asserts (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [ase_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic rxd_in,
  input wire logic txd_out,
  input wire logic irq_out,
  input wire logic wait_mode,
  input wire logic wake_out
);
  import ase_pkg::*;
  logic [7:0] mask_reg;
  logic rd_reg;
  logic [2:0] addr_reg;
  logic st_rd;
  // Mirrors the mask register so that interrupt gating is judged from the ports.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mask_reg <= 8'h00;
    end else if (reg_wr && reg_addr == OFF_MASK) begin
      mask_reg <= reg_wdata & 8'hf8;
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_reg <= 1'b0;
      addr_reg <= 3'h0;
    end else begin
      rd_reg <= reg_rd;
      addr_reg <= reg_addr;
    end
  end
  assign st_rd = rd_reg && addr_reg == OFF_STAT1;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  property p_rdata_rest;
    !rd_reg |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_rest: assert property (p_rdata_rest) else $error("read data not zero outside a read");
  property p_unmapped;
    rd_reg && addr_reg == 3'h7 |-> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped offset read not zero");
  property p_mask_low;
    rd_reg && addr_reg == OFF_MASK |-> reg_rdata[2:0] == 3'b000;
  endproperty
  a_mask_low: assert property (p_mask_low) else $error("mask low bits not zero");
  property p_tc_needs_te;
    st_rd && reg_rdata[FLG_TX_DONE] |-> reg_rdata[FLG_TX_EMPTY];
  endproperty
  a_tc_needs_te: assert property (p_tc_needs_te) else $error("tx complete without tx empty");
  property p_tc_line;
    st_rd && reg_rdata[FLG_TX_DONE] |-> $past(txd_out) && txd_out;
  endproperty
  a_tc_line: assert property (p_tc_line) else $error("serial output low while tx complete");
  property p_irq_on;
    st_rd && (reg_rdata & mask_reg) != 8'h00 && $stable(mask_reg) |-> irq_out || $past(irq_out);
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("enabled flag set but interrupt low");
  property p_irq_quiet;
    mask_reg == 8'h00 && $past(mask_reg) == 8'h00 |-> !irq_out;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt high with all flags masked");
  property p_wake;
    1'b1 |-> wake_out == ($past(wait_mode) && irq_out);
  endproperty
  a_wake: assert property (p_wake) else $error("wake output does not follow interrupt in wait");
  c_overrun: cover property (st_rd && reg_rdata[FLG_OVERRUN]);
  c_idle: cover property (st_rd && reg_rdata[FLG_IDLE]);
  c_wake: cover property (irq_out && wake_out);
endmodule

bind ase_top ase_top_asserts u_chk (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd_in(rxd_in),
  .txd_out(txd_out), .irq_out(irq_out), .wait_mode(wait_mode), .wake_out(wake_out));

/* tb/ase_peer.sv */
// Remote serial node: sends frames on the receive line and captures transmitted frames.
`timescale 1ns/1ps
module ase_peer #(
  parameter int BIT_CYC = 16
) (
  input wire logic core_clk,
  output logic rxd,
  input wire logic txd
);
  initial begin
    rxd = 1'b1;
  end
  // Start bit, data least significant bit first, stop bit; the line then rests high.
  task automatic send(input logic [8:0] d, input logic lng);
    logic [10:0] f;
    f = lng ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
    for (int i = 0; i < (lng ? 11 : 10); i++) begin
      @(posedge core_clk);
      rxd <= f[i];
      repeat (BIT_CYC - 1) @(posedge core_clk);
    end
  endtask
  // Samples each bit in its middle; ok is low on a missing start or a low stop bit.
  task automatic recv(input logic lng, output logic [8:0] d, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    d = 9'h000;
    while (txd !== 1'b0 && n < 4000) begin
      @(posedge core_clk);
      n++;
    end
    if (n < 4000) begin
      repeat (BIT_CYC / 2) @(posedge core_clk);
      for (int i = 0; i < (lng ? 9 : 8); i++) begin
        repeat (BIT_CYC) @(posedge core_clk);
        d[i] = txd;
      end
      repeat (BIT_CYC) @(posedge core_clk);
      ok = txd;
    end
  endtask
endmodule

/* tb/test_async_serial_interrupt_flags.sv */
// Self-checking bench for the serial port flags and interrupt.
`timescale 1ns/1ps
module test_async_serial_interrupt_flags;
  import ase_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic wait_mode = 1'b0;
  logic [7:0] reg_rdata;
  logic rxd_in, txd_out, irq_out, wake_out;
  int fail_count = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h43;
  logic [7:0] st, rv;
  logic [8:0] d1, d2, q1, q2;
  logic ok1, ok2;
  int t_short, t_long, c;

  always #10 core_clk = ~core_clk;

  ase_top u_dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd_in(rxd_in), .txd_out(txd_out),
    .irq_out(irq_out), .wait_mode(wait_mode), .wake_out(wake_out));
  ase_peer u_peer (.core_clk(core_clk), .rxd(rxd_in), .txd(txd_out));

  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [7:0] reset_val(input logic [2:0] a);
    return (a == OFF_STAT1) ? 8'hc0 : 8'h00;
  endfunction
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic poll(input logic [7:0] m, input logic [7:0] v);
    int n;
    n = 0;
    rd(OFF_STAT1, st);
    while ((st & m) !== v && n < 2000) begin
      rd(OFF_STAT1, st);
      n++;
    end
    if (n >= 2000) begin
      chk("status poll timeout", 16'h1, 16'h0);
      final_report();
    end
  endtask
  task automatic wait_irq(output int k);
    k = 0;
    while (irq_out !== 1'b1 && k < 1000) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (k >= 1000) begin
      chk("interrupt wait timeout", 16'h1, 16'h0);
      final_report();
    end
  endtask
  // Clears every receive flag, sends one frame and counts cycles until the idle interrupt.
  task automatic idle_time(input logic lng, input logic [8:0] d, output int k);
    rd(OFF_STAT1, st);
    rd(OFF_DATA_LO, rv);
    wr(OFF_STAT1, 8'h38);
    u_peer.send(d, lng);
    wait_irq(k);
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), rv);
      chk("reset value", rv, reset_val(3'(a)));
    end
    wr(OFF_MASK, 8'hff);
    repeat (2) @(posedge core_clk);
    #1;
    chk("irq with tx flags enabled", irq_out, 1'b1);
    rd(OFF_MASK, rv);
    chk("mask readback", rv, 8'hf8);
    @(posedge core_clk);
    wait_mode <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk("wake in wait mode", wake_out, 1'b1);
    @(posedge core_clk);
    wait_mode <= 1'b0;
    wr(OFF_MASK, 8'h38);
    repeat (2) @(posedge core_clk);
    #1;
    chk("irq with tx flags masked", irq_out, 1'b0);
    rd(OFF_STAT1, st);
    chk("masked flags readable", st, 8'hc0);
    wr(OFF_BAUD_LO, 8'h01);
    wr(OFF_BAUD_HI, 8'h00);
    wr(OFF_CTRL, 8'h02);
    @(posedge core_clk);
    rd(OFF_STAT1, st);
    chk("tc during preamble", st[FLG_TX_DONE], 1'b0);
    poll(8'h40, 8'h40);
    d1 = {1'b0, xs()};
    d2 = 9'h000;
    fork
      begin
        u_peer.recv(1'b0, q1, ok1);
        u_peer.recv(1'b0, q2, ok2);
      end
      begin
        wr(OFF_DATA_LO, d1[7:0]);
        repeat (4) @(posedge core_clk);
        rd(OFF_STAT1, st);
        chk("te after shifter load", st & 8'hc0, 8'h80);
        wr(OFF_DATA_LO, d2[7:0]);
        rd(OFF_STAT1, st);
        chk("te cleared by write", st & 8'hc0, 8'h00);
        poll(8'h80, 8'h80);
        poll(8'hc0, 8'hc0);
      end
    join
    chk("tx frame one", {ok1, q1}, {1'b1, d1});
    chk("tx frame two", {ok2, q2}, {1'b1, d2});
    wr(OFF_CTRL, 8'h06);
    d1 = 9'h0ff;
    u_peer.send(d1, 1'b0);
    poll(8'h20, 8'h20);
    rd(OFF_DATA_LO, rv);
    chk("rx byte", rv, d1[7:0]);
    rd(OFF_STAT1, st);
    chk("rx full cleared", st[FLG_RX_FULL], 1'b0);
    d1 = {1'b0, xs()};
    d2 = {1'b0, xs()};
    u_peer.send(d1, 1'b0);
    u_peer.send(d2, 1'b0);
    repeat (4) @(posedge core_clk);
    rd(OFF_STAT1, st);
    chk("overrun set", st & 8'h28, 8'h28);
    rd(OFF_DATA_LO, rv);
    chk("held byte kept", rv, d1[7:0]);
    rd(OFF_STAT1, st);
    chk("overrun cleared", st & 8'h28, 8'h00);
    wr(OFF_MASK, 8'h10);
    idle_time(1'b0, {1'b0, xs()}, t_short);
    chk("idle delay short", (t_short >= 136 && t_short <= 172), 1'b1);
    wr(OFF_CTRL, 8'h07);
    d2 = 9'({xs(), xs()});
    idle_time(1'b1, d2, t_long);
    chk("idle delay step", 16'(t_long - t_short), 16'h0010);
    rd(OFF_DATA_HI, rv);
    chk("rx ninth bit", rv[DHI_RX_BIT8], d2[8]);
    rd(OFF_STAT1, st);
    rd(OFF_DATA_LO, rv);
    chk("rx long byte", rv, d2[7:0]);
    repeat (2) @(posedge core_clk);
    #1;
    chk("idle cleared", irq_out, 1'b0);
    repeat (400) @(posedge core_clk);
    #1;
    chk("idle held off", irq_out, 1'b0);
    u_peer.send({1'b1, xs()}, 1'b1);
    wait_irq(c);
    chk("idle rearmed", irq_out, 1'b1);
    wr(OFF_CTRL, 8'h0b);
    repeat (40) @(posedge core_clk);
    #1;
    chk("break holds line low", txd_out, 1'b0);
    rd(OFF_STAT1, st);
    chk("tc cleared by break", st[FLG_TX_DONE], 1'b0);
    final_report();
  end
endmodule
